// ==== design/sbt_pkg.sv ====
// package: register map, field layout, reset values and carrier types of the 16-bit timer
`default_nettype none
package sbt_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] SBT_OFF_GLOBAL_IRQ_CTRL = 8'h0B;
   localparam logic [7:0] SBT_OFF_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] SBT_OFF_COUNT_LOW = 8'h0E;
   localparam logic [7:0] SBT_OFF_COUNT_HIGH = 8'h0F;
   localparam logic [7:0] SBT_OFF_CONTROL = 8'h10;
   localparam logic [7:0] SBT_OFF_CMP_LOW = 8'h15;
   localparam logic [7:0] SBT_OFF_CMP_HIGH = 8'h16;
   localparam logic [7:0] SBT_OFF_CMP_MODE = 8'h17;
   localparam logic [7:0] SBT_OFF_IRQ_ENABLES = 8'h8C;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int SBT_BIT_RUN = 0;
   localparam int SBT_BIT_CLK_SEL = 1;
   localparam int SBT_BIT_SYNC_DIS = 2;
   localparam int SBT_BIT_OSC_EN = 3;
   localparam int SBT_BIT_PRESCALE_LO = 4;
   localparam int SBT_BIT_OVF_FLAG = 0;
   localparam int SBT_BIT_OVF_IE = 0;

   // ************************************************************
   // reset values and constants
   // ************************************************************
   localparam logic [7:0] SBT_RST_CONTROL = 8'h00;
   localparam logic [7:0] SBT_RST_FLAGS = 8'h00;
   localparam logic [7:0] SBT_RST_ENABLES = 8'h00;
   localparam logic [7:0] SBT_RST_GLOBAL = 8'h00;
   localparam logic [7:0] SBT_RST_BYTE = 8'h00;
   localparam logic [15:0] SBT_RST_CMP = 16'hFFFF;
   localparam logic [3:0] SBT_MODE_SPECIAL_TRIG = 4'hB;
   localparam logic [7:0] SBT_CONTROL_MASK = 8'h3F;
   localparam logic [15:0] SBT_COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] SBT_COUNT_ZERO = 16'h0000;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic [1:0] unused;
      logic [1:0] prescale;
      logic osc_enable;
      logic sync_disable;
      logic clk_select;
      logic run_enable;
   } sbt_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sbt_bus_req_t;
endpackage
`default_nettype wire

// ==== design/sbt_edge.sv ====
// module: external count input synchroniser, falling-edge arming and rising-edge pulse
`default_nettype none
module sbt_edge
   import sbt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic arm_clear,
   input wire logic sync_disable,
   // count input
   input wire logic count_in,
   // result
   output logic rise_pulse
);
   logic sync_a, sync_b, prev, armed;
   logic next_sync_a, next_sync_b, next_prev, next_armed;
   logic sample;

   // bypass skips the two-flop stage so a sleeping core still sees edges quickly
   always_comb begin
      next_sync_a = count_in;
      next_sync_b = sync_a;
      sample = sync_disable ? count_in : sync_b;
      next_prev = sample;
      next_armed = armed;
      rise_pulse = 1'b0;
      if (arm_clear) begin
         next_armed = 1'b0;
      end else if (prev && !sample) begin
         next_armed = 1'b1;
      end else if (!prev && sample && armed) begin
         rise_pulse = 1'b1;
      end
   end

   // state registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
         armed <= 1'b0;
      end else begin
         sync_a <= next_sync_a;
         sync_b <= next_sync_b;
         prev <= next_prev;
         armed <= next_armed;
      end
   end
endmodule
`default_nettype wire

// ==== design/sbt_presc.sv ====
// module: input clock prescaler 1:1 to 1:8
`default_nettype none
module sbt_presc
   import sbt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic clear,
   input wire logic [1:0] ratio,
   input wire logic tick_in,
   // result
   output logic tick_out
);
   logic [2:0] count, next_count, limit;

   // the ratio code picks the last count before an output tick
   always_comb begin
      case (ratio)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
      next_count = count;
      tick_out = 1'b0;
      if (clear) begin
         next_count = 3'h0;
      end else if (tick_in) begin
         if (count >= limit) begin
            next_count = 3'h0;
            tick_out = 1'b1;
         end else begin
            next_count = count + 3'h1;
         end
      end
   end

   // phase register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 3'h0;
      end else begin
         count <= next_count;
      end
   end
endmodule
`default_nettype wire

// ==== design/sbt_timer.sv ====
// module: 16-bit timer/counter with crystal oscillator, compare trigger reset and overflow interrupt
`default_nettype none
module sbt_timer
   import sbt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // core state
   input wire logic sleep_mode,
   // count sources
   input wire logic external_count_clock_pin,
   input wire logic crystal_in_pin,
   output logic crystal_amp_out_pin,
   output logic crystal_amp_out_en,
   // second compare unit and converter
   input wire logic cmp2_special_trig,
   input wire logic adc_enabled,
   output logic adc_start,
   // interrupt
   output logic irq
);
   // ************************************************************
   // request carrier
   // ************************************************************
   sbt_bus_req_t req;
   // strobes travel with their address and data so every decode looks at one bundle
   assign req = '{
      addr: reg_addr,
      wdata: reg_wdata,
      wr: reg_wr,
      rd: reg_rd
   };

   // ************************************************************
   // register state
   // ************************************************************
   // control, flags, enables and the compare unit's own registers
   sbt_ctrl_t ctrl, next_ctrl;
   logic [7:0] flags, next_flags;
   logic [7:0] enables, next_enables;
   logic [7:0] global_ctrl, next_global_ctrl;
   logic [15:0] compare, next_compare;
   logic [3:0] cmp_mode, next_cmp_mode;
   logic [7:0] rdata_q, next_rdata;
   logic irq_q, next_irq;

   // decoded writes
   // the count bytes are separate 8-bit stores: a 16-bit value takes two writes,
   // so software should stop the counter first or it may catch a carry between them
   logic wr_low, wr_high, wr_ctrl;
   assign wr_low = req.wr && (req.addr == SBT_OFF_COUNT_LOW);
   assign wr_high = req.wr && (req.addr == SBT_OFF_COUNT_HIGH);
   assign wr_ctrl = req.wr && (req.addr == SBT_OFF_CONTROL);

   // ************************************************************
   // counter state
   // ************************************************************
   logic [15:0] count, next_count;
   // match_q remembers the previous compare hit so each arrival triggers once
   logic match_q, next_match_q;
   logic amp_q, next_amp_q;
   logic amp_en_q, next_amp_en_q;
   // adc_q holds the registered conversion start pulse
   logic adc_q, next_adc_q;

   // ************************************************************
   // count source selection
   // ************************************************************
   logic ext_source, ext_rise, raw_tick, presc_tick, arm_clear;

   // the crystal replaces the external pin as source when the oscillator runs
   assign ext_source = ctrl.osc_enable ? crystal_in_pin : external_count_clock_pin;
   // both sources pass through one synchroniser, so sync disable applies to each
   // re-arm on disable or on a change into counter mode so the first edge is never a rising one
   // a pin that idles low therefore costs one full pulse before counting starts
   assign arm_clear = !ctrl.run_enable || !ctrl.clk_select ||
                      (wr_ctrl && !(ctrl.run_enable && ctrl.clk_select));

   // edge detector with its own synchroniser; arming is cleared from here
   sbt_edge u_edge (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .arm_clear(arm_clear),
      .sync_disable(ctrl.sync_disable),
      .count_in(ext_source),
      .rise_pulse(ext_rise)
   );

   // instruction-cycle counting halts in sleep; external counting does not
   // the prescaler sees raw ticks only while the run enable is set
   always_comb begin
      raw_tick = 1'b0;
      if (ctrl.run_enable) begin
         if (ctrl.clk_select) begin
            raw_tick = ext_rise;
         end else begin
            raw_tick = !sleep_mode;
         end
      end
   end

   // one divider after the source mux serves every source
   // a counter byte write restarts its phase
   sbt_presc u_presc (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(wr_low || wr_high),
      .ratio(ctrl.prescale),
      .tick_in(raw_tick),
      .tick_out(presc_tick)
   );

   // ************************************************************
   // crystal oscillator amplifier
   // ************************************************************
   // sleep is not an input here at all, so sleep cannot stop the amplifier
   // inverting amplifier: the output is the crystal input turned over, one clock late
   // no start-up timer: the first cycles after enabling may be junk,
   // and software has to wait them out before trusting the count
   always_comb begin
      next_amp_en_q = ctrl.osc_enable;
      next_amp_q = ctrl.osc_enable ? !crystal_in_pin : 1'b0;
   end

   // amplifier registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         amp_q <= 1'b0;
         amp_en_q <= 1'b0;
      end else begin
         amp_q <= next_amp_q;
         amp_en_q <= next_amp_en_q;
      end
   end

   // ************************************************************
   // counter, compare trigger and overflow
   // ************************************************************
   logic trig_mode, match_now, trig1, any_trig, wrap;

   // trigger resets only work reliably in timer or synchronised mode; software keeps to that
   assign trig_mode = (cmp_mode == SBT_MODE_SPECIAL_TRIG);
   assign match_now = trig_mode && (count == compare);
   // one trigger per arrival at the compare value
   // without the edge a compare of zero would hold the counter at zero
   assign trig1 = match_now && !match_q;
   assign any_trig = trig1 || cmp2_special_trig;
   assign wrap = presc_tick && (count == SBT_COUNT_MAX);

   // priority: software write, then trigger clear, then prescaled count
   // the conversion start is registered: it leaves clean one cycle late and lasts as long as the enabled trigger
   always_comb begin
      next_count = count;
      next_match_q = match_now;
      next_adc_q = cmp2_special_trig && adc_enabled;
      if (wr_low || wr_high) begin
         // a write wins over a trigger in the same cycle
         if (wr_low) begin
            next_count[7:0] = req.wdata;
         end
         if (wr_high) begin
            next_count[15:8] = req.wdata;
         end
      end else if (any_trig) begin
         // both unit triggers land here; only the first unit's comes from the compare
         next_count = SBT_COUNT_ZERO;
      end else if (presc_tick) begin
         // the 16-bit add wraps FFFF to 0000 by itself
         next_count = count + 16'h0001;
      end
   end

   // counter registers
   // the count resets to zero; the byte registers keep no separate holding copy
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= SBT_COUNT_ZERO;
         match_q <= 1'b0;
         adc_q <= 1'b0;
      end else begin
         count <= next_count;
         match_q <= next_match_q;
         adc_q <= next_adc_q;
      end
   end

   // ************************************************************
   // register file and interrupt
   // ************************************************************
   logic ovf_set;
   // the global interrupt control byte is only a store; irq is gated by the enables alone
   // a trigger clear is not a wrap, so it never reaches the flag
   // a counter write that lands on the wrap edge also wins, so no flag either
   assign ovf_set = wrap && !any_trig && !wr_low && !wr_high;

   // software writes, then the hardware flag set, then the interrupt level
   // irq uses next values so it rises on the same edge as the flag
   always_comb begin
      next_ctrl = ctrl;
      next_flags = flags;
      next_enables = enables;
      next_global_ctrl = global_ctrl;
      next_compare = compare;
      next_cmp_mode = cmp_mode;
      if (req.wr) begin
         case (req.addr)
            SBT_OFF_CONTROL: next_ctrl = sbt_ctrl_t'(req.wdata & SBT_CONTROL_MASK);
            SBT_OFF_IRQ_FLAGS: next_flags = flags & ~req.wdata; // write one to clear
            SBT_OFF_IRQ_ENABLES: next_enables = req.wdata;
            SBT_OFF_GLOBAL_IRQ_CTRL: next_global_ctrl = req.wdata;
            SBT_OFF_CMP_LOW: next_compare[7:0] = req.wdata;
            SBT_OFF_CMP_HIGH: next_compare[15:8] = req.wdata;
            SBT_OFF_CMP_MODE: next_cmp_mode = req.wdata[3:0];
            default: next_compare = compare;
         endcase
      end
      // hardware set wins over a software clear in the same cycle
      if (ovf_set) begin
         next_flags[SBT_BIT_OVF_FLAG] = 1'b1;
      end
      next_irq = |(next_flags & next_enables);
   end

   // read mux: data stand in the cycle after the strobe only
   // idle and unmapped cycles read zero, so a stale byte never looks like data
   always_comb begin
      next_rdata = 8'h00;
      if (req.rd) begin
         case (req.addr)
            SBT_OFF_CONTROL: next_rdata = ctrl;
            SBT_OFF_IRQ_FLAGS: next_rdata = flags;
            SBT_OFF_IRQ_ENABLES: next_rdata = enables;
            SBT_OFF_GLOBAL_IRQ_CTRL: next_rdata = global_ctrl;
            SBT_OFF_COUNT_LOW: next_rdata = count[7:0];
            SBT_OFF_COUNT_HIGH: next_rdata = count[15:8];
            SBT_OFF_CMP_LOW: next_rdata = compare[7:0];
            SBT_OFF_CMP_HIGH: next_rdata = compare[15:8];
            SBT_OFF_CMP_MODE: next_rdata = {4'h0, cmp_mode};
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // register file registers
   // the compare pair resets to all ones, so a trigger mode set early waits a full count
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= sbt_ctrl_t'(SBT_RST_CONTROL);
         flags <= SBT_RST_FLAGS;
         enables <= SBT_RST_ENABLES;
         global_ctrl <= SBT_RST_GLOBAL;
         compare <= SBT_RST_CMP;
         cmp_mode <= SBT_RST_BYTE[3:0];
         rdata_q <= SBT_RST_BYTE;
         irq_q <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         flags <= next_flags;
         enables <= next_enables;
         global_ctrl <= next_global_ctrl;
         compare <= next_compare;
         cmp_mode <= next_cmp_mode;
         rdata_q <= next_rdata;
         irq_q <= next_irq;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // every output leaves straight from a register, so no decode glitch reaches a pin
   assign reg_rdata = rdata_q;
   assign irq = irq_q;
   assign crystal_amp_out_pin = amp_q;
   assign crystal_amp_out_en = amp_en_q;
   assign adc_start = adc_q;
endmodule
`default_nettype wire

// ==== testbench/sbt_timer_assertions.sv ====
// checker: port-level assertions and covers for the 16-bit timer
`default_nettype none
module sbt_timer_assertions
   import sbt_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // pins
   input wire logic sleep_mode,
   input wire logic crystal_in_pin,
   input wire logic crystal_amp_out_pin,
   input wire logic crystal_amp_out_en,
   input wire logic cmp2_special_trig,
   input wire logic adc_enabled,
   input wire logic adc_start,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // read port: data only in the slot after a read, top control bits empty
   AST_RDATA_SLOT: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its slot");
   AST_CTRL_TOP: assert property (reg_rd && reg_addr == SBT_OFF_CONTROL |=> reg_rdata[7:6] == 2'b00)
      else $error("control bits 7:6 not zero");
   AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   // crystal amplifier follows the enable bit two edges after the control write
   AST_OSC_EN: assert property (reg_wr && reg_addr == SBT_OFF_CONTROL
      |-> ##2 crystal_amp_out_en == $past(reg_wdata[3], 2))
      else $error("amplifier enable does not follow control");
   AST_AMP_QUIET: assert property (!crystal_amp_out_en |-> crystal_amp_out_pin == 1'b0)
      else $error("amplifier drives while disabled");
   AST_AMP_INV: assert property (crystal_amp_out_en && $past(crystal_amp_out_en)
      |-> crystal_amp_out_pin == !$past(crystal_in_pin))
      else $error("amplifier output not inverted input");
   // conversion start only from an enabled second-unit trigger
   AST_ADC_GO: assert property (cmp2_special_trig && adc_enabled |=> adc_start)
      else $error("conversion start missing");
   AST_ADC_HOLD: assert property (!(cmp2_special_trig && adc_enabled) |=> !adc_start)
      else $error("conversion start without cause");
   // interrupt is sticky until the flag is cleared or masked
   AST_IRQ_STICKY: assert property (irq && !(reg_wr && (reg_addr == SBT_OFF_IRQ_FLAGS ||
      reg_addr == SBT_OFF_IRQ_ENABLES)) |=> irq)
      else $error("interrupt dropped by itself");
   AST_IRQ_CLEAR: assert property (reg_wr && reg_addr == SBT_OFF_IRQ_FLAGS && reg_wdata[0] |=> !irq)
      else $error("interrupt survives flag clear");
   AST_IRQ_MASK: assert property (reg_wr && reg_addr == SBT_OFF_IRQ_ENABLES && !reg_wdata[0] |=> !irq [*2])
      else $error("masked interrupt raised");
   // main scenarios
   cover property (irq);
   cover property (adc_start);
   cover property (crystal_amp_out_en && sleep_mode);
endmodule
bind sbt_timer sbt_timer_assertions u_chk (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
   .crystal_in_pin(crystal_in_pin), .crystal_amp_out_pin(crystal_amp_out_pin),
   .crystal_amp_out_en(crystal_amp_out_en), .cmp2_special_trig(cmp2_special_trig),
   .adc_enabled(adc_enabled), .adc_start(adc_start), .irq(irq));
`default_nettype wire

// ==== testbench/sbt_far.sv ====
// partner model: external count pin and crystal source
`default_nettype none
module sbt_far (
   // clock
   input wire logic core_clk,
   // crystal run request
   input wire logic xtal_run,
   // pins toward the timer
   output logic ext_pin,
   output logic xtal_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] phase = 2'b00;
   initial ext_pin = 1'b1;
   initial xtal_pin = 1'b0;
   // crystal half period is four cycles; it stands still when stopped
   always @(posedge core_clk) begin
      if (xtal_run) begin
         phase <= phase + 2'd1;
         if (phase == 2'd3) begin
            xtal_pin <= !xtal_pin;
         end
      end
   end
   task automatic set_pin(input logic b);
      @(posedge core_clk);
      ext_pin <= b;
   endtask
   // each pulse: three cycles low, then three high
   task automatic pulses(input int n);
      repeat (n) begin
         set_pin(1'b0);
         repeat (2) @(posedge core_clk);
         set_pin(1'b1);
         repeat (2) @(posedge core_clk);
      end
   endtask
endmodule
`default_nettype wire

// ==== testbench/sbt_timer_bench.sv ====
// testbench: register-level tests of the 16-bit timer
`default_nettype none
module sbt_timer_bench
   import sbt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sleep_mode = 1'b0;
   logic trig = 1'b0;
   logic adc_en = 1'b0;
   logic xtal_run = 1'b0;
   logic [7:0] reg_rdata;
   logic ext_pin, xtal_pin, amp_pin, amp_en, adc_start, irq;
   logic [7:0] v, w;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   initial begin
      forever #20 core_clk = ~core_clk;
   end
   sbt_timer u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
      .external_count_clock_pin(ext_pin), .crystal_in_pin(xtal_pin), .crystal_amp_out_pin(amp_pin),
      .crystal_amp_out_en(amp_en), .cmp2_special_trig(trig), .adc_enabled(adc_en),
      .adc_start(adc_start), .irq(irq));
   sbt_far u_far (.core_clk(core_clk), .xtal_run(xtal_run), .ext_pin(ext_pin), .xtal_pin(xtal_pin));
   // ************************************************************
   // bus tasks and checks
   // ************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic t = 1'b0);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      trig <= t;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      trig <= 1'b0;
   endtask
   // data is taken just after the edge that registered it
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic pulse_trig(input logic exp);
      @(posedge core_clk);
      trig <= 1'b1;
      @(posedge core_clk);
      trig <= 1'b0;
      #1 chk({7'h00, adc_start}, {7'h00, exp});
   endtask
   // run from FFFD across the wrap, then stop
   task automatic ovf();
      wr(SBT_OFF_COUNT_LOW, 8'hFD);
      wr(SBT_OFF_COUNT_HIGH, 8'hFF);
      wr(SBT_OFF_CONTROL, 8'h01);
      repeat (8) @(posedge core_clk);
      wr(SBT_OFF_CONTROL, 8'h00);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // hang guard, well above the fewer than one thousand cycles the tests need
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rc(SBT_OFF_CONTROL, SBT_RST_CONTROL);
      rc(SBT_OFF_IRQ_FLAGS, SBT_RST_FLAGS);
      rc(SBT_OFF_IRQ_ENABLES, SBT_RST_ENABLES);
      rc(8'h20, 8'h00);
      wr(SBT_OFF_GLOBAL_IRQ_CTRL, 8'hA5);
      rc(SBT_OFF_GLOBAL_IRQ_CTRL, 8'hA5);
      wr(SBT_OFF_CONTROL, 8'hFE);
      rc(SBT_OFF_CONTROL, 8'h3E);
      wr(SBT_OFF_CONTROL, 8'h00);
      // overflow, sticky flag, mask
      wr(SBT_OFF_IRQ_ENABLES, 8'h01);
      ovf();
      rc(SBT_OFF_IRQ_FLAGS, 8'h01);
      rc(SBT_OFF_COUNT_HIGH, 8'h00);
      #1 chk({7'h00, irq}, 8'h01);
      wr(SBT_OFF_IRQ_FLAGS, 8'h01);
      #1 chk({7'h00, irq}, 8'h00);
      wr(SBT_OFF_IRQ_ENABLES, 8'h00);
      ovf();
      rc(SBT_OFF_IRQ_FLAGS, 8'h01);
      #1 chk({7'h00, irq}, 8'h00);
      wr(SBT_OFF_IRQ_FLAGS, 8'h01);
      rc(SBT_OFF_IRQ_FLAGS, 8'h00);
      // every prescale code, from a cleared prescaler
      for (int i = 0; i < 4; i++) begin
         wr(SBT_OFF_COUNT_LOW, 8'h00);
         wr(SBT_OFF_CONTROL, {2'b00, i[1:0], 4'h1});
         repeat (64) @(posedge core_clk);
         wr(SBT_OFF_CONTROL, 8'h00);
         rd(SBT_OFF_COUNT_LOW, v);
         chk({7'h00, v >= (8'd64 >> i) && v <= (8'd68 >> i) + 8'd1}, 8'h01);
      end
      // counter mode: a rise before any fall is not counted
      u_far.set_pin(1'b0);
      wr(SBT_OFF_COUNT_LOW, 8'h00);
      wr(SBT_OFF_CONTROL, 8'h03);
      u_far.set_pin(1'b1);
      u_far.pulses(5);
      repeat (4) @(posedge core_clk);
      rc(SBT_OFF_COUNT_LOW, 8'h05);
      wr(SBT_OFF_CONTROL, 8'h07);
      wr(SBT_OFF_COUNT_LOW, 8'h00);
      u_far.pulses(3);
      repeat (4) @(posedge core_clk);
      rc(SBT_OFF_COUNT_LOW, 8'h03);
      // crystal counting in sleep, after a start-up delay
      xtal_run <= 1'b1;
      sleep_mode <= 1'b1;
      wr(SBT_OFF_CONTROL, 8'h0B);
      repeat (40) @(posedge core_clk);
      #1 chk({7'h00, amp_en}, 8'h01);
      rd(SBT_OFF_COUNT_LOW, v);
      repeat (64) @(posedge core_clk);
      rd(SBT_OFF_COUNT_LOW, w);
      chk({7'h00, w - v >= 8'd7 && w - v <= 8'd9}, 8'h01);
      wr(SBT_OFF_CONTROL, 8'h01);
      rd(SBT_OFF_COUNT_LOW, v);
      repeat (10) @(posedge core_clk);
      rd(SBT_OFF_COUNT_LOW, w);
      chk(w, v);
      sleep_mode <= 1'b0;
      xtal_run <= 1'b0;
      wr(SBT_OFF_CONTROL, 8'h00);
      repeat (2) @(posedge core_clk);
      #1 chk({7'h00, amp_en}, 8'h00);
      // compare pair as period, no overflow flag
      wr(SBT_OFF_CMP_LOW, 8'h05);
      wr(SBT_OFF_CMP_HIGH, 8'h00);
      wr(SBT_OFF_CMP_MODE, {4'h0, SBT_MODE_SPECIAL_TRIG});
      wr(SBT_OFF_COUNT_LOW, 8'h00);
      wr(SBT_OFF_COUNT_HIGH, 8'h00);
      wr(SBT_OFF_CONTROL, 8'h01);
      repeat (50) @(posedge core_clk);
      wr(SBT_OFF_CONTROL, 8'h00);
      rd(SBT_OFF_COUNT_LOW, v);
      chk({7'h00, v <= 8'h05}, 8'h01);
      rc(SBT_OFF_IRQ_FLAGS, 8'h00);
      rc(SBT_OFF_CMP_LOW, 8'h05);
      // trigger at FFFF meets the wrap: the count clears and the flag stays low
      wr(SBT_OFF_CMP_LOW, 8'hFF);
      wr(SBT_OFF_CMP_HIGH, 8'hFF);
      ovf();
      rc(SBT_OFF_IRQ_FLAGS, 8'h00);
      rc(SBT_OFF_COUNT_HIGH, 8'h00);
      wr(SBT_OFF_CMP_MODE, 8'h00);
      // write beats a coincident trigger; a lone trigger clears
      adc_en <= 1'b1;
      wr(SBT_OFF_COUNT_HIGH, 8'h12);
      wr(SBT_OFF_COUNT_LOW, 8'h40, 1'b1);
      rc(SBT_OFF_COUNT_HIGH, 8'h12);
      rc(SBT_OFF_COUNT_LOW, 8'h40);
      pulse_trig(1'b1);
      rc(SBT_OFF_COUNT_HIGH, 8'h00);
      adc_en <= 1'b0;
      pulse_trig(1'b0);
      print_verdict();
   end
endmodule
`default_nettype wire
